// ### hdl/rtd_input_channel_regs.sv
// register bank for the third input channel: configuration and measurements
`timescale 1ns/1ps
`default_nettype none

// Contract
// RQ1 - bits 7:6 pick sensor type, reset 00
// RQ2 - bit 5 picks temperature or resistance
// RQ3 - bit 4 picks two/four or three wire
// RQ4 - bit 3 picks 50 or 60 Hz rejection
// RQ5 - bits 2:0 pick filter, reset 010
// RQ6 - bits 15:8 ignore writes, read zero
// RQ7 - integer word scale follows mode and type
// RQ8 - float value split across two words
// RQ9 - float word order follows module control bit
// RQ10 - both measurement forms update together
module rtd_input_channel_regs
   import rtd_pkg::*;
(
   input wire logic i_clk,              // 25 MHz clock
   input wire logic i_rst,              // synchronous reset, high
   input wire logic i_wr,               // register write strobe
   input wire logic i_rd,               // register read strobe
   input wire logic [15:0] i_addr,      // register word address
   input wire logic [15:0] i_wdata,     // write data
   input wire logic i_float_swap,       // module word-order control bit
   input wire logic i_conv_valid,       // conversion done pulse
   input wire rtd_meas_s i_conv,        // converted measurement
   output rtd_cfg_s o_cfg,              // configuration to acquisition
   output logic [1:0] o_int_scale,      // scale of integer word
   output logic [15:0] o_rdata,         // read data
   output logic o_rvalid,               // read answer pulse
   output logic o_rerr                  // unmapped address pulse
);

   rtd_cfg_s cfg_r;
   rtd_cfg_s cfg_nxt;
   rtd_meas_s meas_r;
   logic [1:0] scale_r;
   logic [1:0] scale_nxt;
   logic [15:0] rdata_r;
   logic rvalid_r;
   logic rerr_r;

   // address decode
   wire logic hit_int = (i_addr == RTD_ADDR_MEAS_INT);
   wire logic hit_hi = (i_addr == RTD_ADDR_FLOAT_HI);
   wire logic hit_lo = (i_addr == RTD_ADDR_FLOAT_LO);
   wire logic hit_cfg = (i_addr == RTD_ADDR_CFG);
   wire logic hit_any = hit_int | hit_hi | hit_lo | hit_cfg;
   wire logic cfg_we = i_wr & hit_cfg;

   // RQ6 upper byte dropped
   wire rtd_cfg_s wr_cfg = rtd_cfg_s'(i_wdata[RTD_CFG_USED_W-1:0]);
   // RQ1 RQ2 RQ3 RQ4 RQ5 field capture
   assign cfg_nxt = cfg_we ? wr_cfg : cfg_r;

   // RQ7 integer word scale
   wire logic is_100_ohm = (cfg_r.sensor_type == RTD_TYPE_PLATINUM_100_OHM)
      | (cfg_r.sensor_type == RTD_TYPE_NICKEL_100_OHM);
   assign scale_nxt = !cfg_r.measure_resist ? RTD_SCALE_TENTH_DEGC :
      is_100_ohm ? RTD_SCALE_HUNDREDTH_OHM : RTD_SCALE_TENTH_OHM;

   // RQ9 word order select
   wire logic [15:0] float_upper_word;
   wire logic [15:0] float_lower_word;
   assign {float_upper_word, float_lower_word} = meas_r.float_word;
   wire logic [15:0] word_at_hi = i_float_swap ? float_lower_word : float_upper_word;
   wire logic [15:0] word_at_lo = i_float_swap ? float_upper_word : float_lower_word;

   // RQ6 read mux, upper byte zero
   // RQ8 float words readable
   wire logic [15:0] rd_mux =
      hit_cfg ? {RTD_CFG_PAD, cfg_r} :
      hit_int ? meas_r.int_word :
      hit_hi ? word_at_hi :
      hit_lo ? word_at_lo : RTD_WORD_ZERO;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cfg_r <= rtd_cfg_s'(RTD_CFG_RST);
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // RQ10 single capture of both forms
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meas_r <= '{int_word: RTD_WORD_ZERO, float_word: RTD_FLOAT_ZERO};
      end else if (i_conv_valid) begin
         meas_r <= i_conv;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         scale_r <= RTD_SCALE_TENTH_DEGC;
      end else begin
         scale_r <= scale_nxt;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rdata_r <= RTD_WORD_ZERO;
         rvalid_r <= 1'b0;
         rerr_r <= 1'b0;
      end else begin
         rdata_r <= i_rd ? rd_mux : rdata_r;
         rvalid_r <= i_rd;
         rerr_r <= (i_rd | i_wr) & ~hit_any;
      end
   end

   assign o_cfg = cfg_r;
   assign o_int_scale = scale_r;
   assign o_rdata = rdata_r;
   assign o_rvalid = rvalid_r;
   assign o_rerr = rerr_r;

   // checks
   default clocking chk_cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   logic past_valid_r;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         past_valid_r <= 1'b0;
      end else begin
         past_valid_r <= 1'b1;
      end
   end

   // views of the read word and reset word for the checks
   wire rtd_cfg_s rst_cfg = rtd_cfg_s'(RTD_CFG_RST);
   wire logic [RTD_CFG_USED_W-1:0] rdata_pad;
   wire rtd_cfg_s rdata_cfg;
   assign {rdata_pad, rdata_cfg} = rdata_r;

   chk_cfg_reset_value: assert property ( // RQ1 RQ5
      !past_valid_r && !cfg_we |=> o_cfg == rtd_cfg_s'(RTD_CFG_RST))
      else $error("configuration not at reset value after reset");

   chk_cfg_write_takes: assert property ( // RQ2
      cfg_we |=> o_cfg == $past(wr_cfg))
      else $error("configuration write not stored");

   chk_cfg_holds: assert property ( // RQ3
      !cfg_we |=> $stable(o_cfg))
      else $error("configuration changed without a write");

   chk_upper_zero: assert property ( // RQ6
      i_rd && hit_cfg |=> o_rvalid && rdata_pad == RTD_CFG_PAD)
      else $error("unused configuration bits read nonzero");

   chk_cfg_readback: assert property ( // RQ4
      i_rd && hit_cfg && !cfg_we |=> rdata_cfg == o_cfg)
      else $error("configuration read back wrong");

   chk_read_old_cfg: assert property (
      i_rd && cfg_we
      |=> rdata_cfg == $past(o_cfg))
      else $error("read beside a write did not return the old value");

   // configuration fields
   chk_type_write: assert property ( // RQ1
      cfg_we
      |=> o_cfg.sensor_type == $past(wr_cfg.sensor_type))
      else $error("sensor type field not stored");

   chk_mode_write: assert property ( // RQ2
      cfg_we
      |=> o_cfg.measure_resist == $past(wr_cfg.measure_resist))
      else $error("measure type bit not stored");

   chk_wire_write: assert property ( // RQ3
      cfg_we
      |=> o_cfg.three_wire == $past(wr_cfg.three_wire))
      else $error("wiring bit not stored");

   chk_reject_write: assert property ( // RQ4
      cfg_we
      |=> o_cfg.reject_60hz == $past(wr_cfg.reject_60hz))
      else $error("rejection bit not stored");

   chk_filter_write: assert property ( // RQ5
      cfg_we
      |=> o_cfg.filter_code == $past(wr_cfg.filter_code))
      else $error("filter field not stored");

   chk_type_reset: assert property ( // RQ1
      $fell(i_rst)
      |-> o_cfg.sensor_type == RTD_TYPE_PLATINUM_100_OHM)
      else $error("sensor type not cleared by reset");

   chk_flags_reset: assert property ( // RQ2 RQ3 RQ4
      $fell(i_rst)
      |-> !o_cfg.measure_resist && !o_cfg.three_wire && !o_cfg.reject_60hz)
      else $error("mode bits not cleared by reset");

   chk_filter_reset: assert property ( // RQ5
      $fell(i_rst)
      |-> o_cfg.filter_code == rst_cfg.filter_code)
      else $error("filter field not at reset code");

   chk_int_scale: assert property ( // RQ7
      past_valid_r && $past(o_cfg.measure_resist) == 1'b0 |-> o_int_scale == RTD_SCALE_TENTH_DEGC)
      else $error("temperature mode scale wrong");

   chk_scale_ohm: assert property ( // RQ7
      past_valid_r && $past(o_cfg.measure_resist)
      && ($past(o_cfg.sensor_type) == RTD_TYPE_PLATINUM_500_OHM
      || $past(o_cfg.sensor_type) == RTD_TYPE_PLATINUM_1000_OHM)
      |-> o_int_scale == RTD_SCALE_TENTH_OHM)
      else $error("large sensor resistance scale wrong");

   chk_scale_small: assert property ( // RQ7
      past_valid_r && $past(o_cfg.measure_resist)
      && ($past(o_cfg.sensor_type) == RTD_TYPE_PLATINUM_100_OHM
      || $past(o_cfg.sensor_type) == RTD_TYPE_NICKEL_100_OHM)
      |-> o_int_scale == RTD_SCALE_HUNDREDTH_OHM)
      else $error("small sensor resistance scale wrong");

   chk_int_read: assert property ( // RQ7
      i_rd && hit_int
      |=> o_rdata == $past(meas_r.int_word))
      else $error("integer word read wrong");

   chk_meas_together: assert property ( // RQ10
      i_conv_valid ##1 (i_rd && hit_int) |=> o_rdata == $past(i_conv.int_word, 2))
      else $error("integer word not from last conversion");

   chk_float_order: assert property ( // RQ9
      i_rd && hit_hi && !i_float_swap
      |=> o_rdata == $past(float_upper_word))
      else $error("float upper word order wrong");

   chk_float_swapped: assert property ( // RQ9
      i_rd && hit_lo && i_float_swap
      |=> o_rdata == $past(float_upper_word))
      else $error("swapped float word order wrong");

   chk_float_lower: assert property ( // RQ8
      i_rd && hit_lo && !i_float_swap
      |=> o_rdata == $past(float_lower_word))
      else $error("float lower word read wrong");

   chk_float_swap_hi: assert property ( // RQ9
      i_rd && hit_hi && i_float_swap
      |=> o_rdata == $past(float_lower_word))
      else $error("swapped float upper address wrong");

   chk_meas_capture: assert property ( // RQ10
      i_conv_valid
      |=> meas_r == $past(i_conv))
      else $error("conversion not captured whole");

   chk_meas_hold: assert property ( // RQ10
      !i_conv_valid
      |=> $stable(meas_r))
      else $error("measurement changed without a conversion");

   chk_meas_not_written: assert property (
      i_wr && (hit_int || hit_hi || hit_lo) && !i_conv_valid
      |=> $stable(meas_r))
      else $error("read-only measurement word was written");

   chk_read_answer: assert property (
      i_rd |=> o_rvalid ##1 !o_rvalid || $past(i_rd))
      else $error("read answer not a one-cycle pulse");

   // read port answers
   chk_unmapped_err: assert property (
      (i_rd || i_wr) && !hit_any
      |=> o_rerr)
      else $error("unmapped access not flagged");

   chk_mapped_quiet: assert property (
      !((i_rd || i_wr) && !hit_any)
      |=> !o_rerr)
      else $error("error flagged without an unmapped access");

   chk_unmapped_zero: assert property (
      i_rd && !hit_any
      |=> o_rdata == RTD_WORD_ZERO)
      else $error("unmapped read returned nonzero");

   chk_rdata_holds: assert property (
      !i_rd
      |=> $stable(o_rdata))
      else $error("read data changed without a read");

   chk_no_answer: assert property (
      !i_rd
      |=> !o_rvalid)
      else $error("read answer without a read");

   cov_cfg_write: cover property (cfg_we ##1 i_rd && hit_cfg);
   cov_conv_read: cover property (i_conv_valid ##[1:4] (i_rd && hit_lo));
   cov_swap_read: cover property (i_float_swap && i_rd && hit_hi);
   cov_unmapped: cover property (o_rerr);
   cov_back_to_back: cover property (i_conv_valid ##1 (i_rd && hit_int));
endmodule

`default_nettype wire

// ### shared/rtd_pkg.sv
// constants and carrier types for the third input channel register bank
package rtd_pkg;
   // register word addresses on the register port
   localparam logic [15:0] RTD_ADDR_MEAS_INT = 16'h9c45;
   localparam logic [15:0] RTD_ADDR_FLOAT_HI = 16'h9c4b;
   localparam logic [15:0] RTD_ADDR_FLOAT_LO = 16'h9c4c;
   localparam logic [15:0] RTD_ADDR_CFG = 16'h9c67;

   // configuration word layout
   localparam int RTD_CFG_USED_W = 8;
   localparam logic [7:0] RTD_CFG_RST = 8'h02;
   localparam logic [7:0] RTD_CFG_PAD = 8'h00;

   // sensor type codes, bits 7:6
   localparam logic [1:0] RTD_TYPE_PLATINUM_100_OHM = 2'h0;
   localparam logic [1:0] RTD_TYPE_NICKEL_100_OHM = 2'h1;
   localparam logic [1:0] RTD_TYPE_PLATINUM_500_OHM = 2'h2;
   localparam logic [1:0] RTD_TYPE_PLATINUM_1000_OHM = 2'h3;

   // scale of the integer measurement word
   localparam logic [1:0] RTD_SCALE_TENTH_DEGC = 2'h0;
   localparam logic [1:0] RTD_SCALE_HUNDREDTH_OHM = 2'h1;
   localparam logic [1:0] RTD_SCALE_TENTH_OHM = 2'h2;

   localparam logic [15:0] RTD_WORD_ZERO = 16'h0000;
   localparam logic [31:0] RTD_FLOAT_ZERO = 32'h0000_0000;

   // bit 7 down to bit 0 of the configuration word
   typedef struct packed {
      logic [1:0] sensor_type;
      logic measure_resist;
      logic three_wire;
      logic reject_60hz;
      logic [2:0] filter_code;
   } rtd_cfg_s;

   typedef struct packed {
      logic [15:0] int_word;
      logic [31:0] float_word;
   } rtd_meas_s;
endpackage

// ### testbench/test_rtd_input_channel_regs.sv
// self-checking bench for the third input channel register bank
`timescale 1ns/1ps
`default_nettype none
module test_rtd_input_channel_regs;
   import rtd_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [15:0] i_addr = 16'h0000;
   logic [15:0] i_wdata = 16'h0000;
   logic i_float_swap = 1'b0;
   logic i_conv_valid = 1'b0;
   rtd_meas_s i_conv = '0;
   rtd_cfg_s o_cfg;
   logic [1:0] o_int_scale;
   logic [15:0] o_rdata;
   logic o_rvalid;
   logic o_rerr;
   int failures = 0;
   int tests_run = 0;
   rtd_input_channel_regs dut (.i_clk, .i_rst, .i_wr, .i_rd, .i_addr, .i_wdata, .i_float_swap,
      .i_conv_valid, .i_conv, .o_cfg, .o_int_scale, .o_rdata, .o_rvalid, .o_rerr);
   initial begin
      forever #20 i_clk = ~i_clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (failures == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // one register cycle; answer and error pulse judged one cycle later
   task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data);
      logic err;
      err = !(addr inside {RTD_ADDR_MEAS_INT, RTD_ADDR_FLOAT_HI, RTD_ADDR_FLOAT_LO, RTD_ADDR_CFG});
      @(posedge i_clk);
      #1;
      i_wr = wr;
      i_rd = !wr;
      i_addr = addr;
      i_wdata = data;
      @(posedge i_clk);
      #1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      check({15'h0000, o_rvalid}, {15'h0000, !wr});
      check({15'h0000, o_rerr}, {15'h0000, err});
   endtask
   task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
      access(1'b0, addr, 16'h0000);
      check(o_rdata, exp);
   endtask
   task automatic conv(input rtd_meas_s m);
      @(posedge i_clk);
      #1;
      i_conv_valid = 1'b1;
      i_conv = m;
      @(posedge i_clk);
      #1;
      i_conv_valid = 1'b0;
   endtask
   task automatic t_reset();
      check({8'h00, o_cfg}, 16'h0002);
      check({14'h0000, o_int_scale}, {14'h0000, RTD_SCALE_TENTH_DEGC});
      rd(RTD_ADDR_CFG, 16'h0002);
   endtask
   task automatic t_config();
      logic [7:0] v;
      logic [1:0] sc;
      for (int i = 0; i < 8; i++) begin
         v = {i[2:1], i[0], i[0], !i[0], i[2:0]};
         sc = !i[0] ? RTD_SCALE_TENTH_DEGC : (i[2] ? RTD_SCALE_TENTH_OHM : RTD_SCALE_HUNDREDTH_OHM);
         access(1'b1, RTD_ADDR_CFG, {8'hff, v});
         check({8'h00, o_cfg}, {8'h00, v});
         rd(RTD_ADDR_CFG, {8'h00, v});
         check({14'h0000, o_int_scale}, {14'h0000, sc});
      end
   endtask
   task automatic t_meas();
      conv({16'h1234, 32'h4049_0fdb});
      access(1'b1, RTD_ADDR_MEAS_INT, 16'hbeef);
      rd(RTD_ADDR_MEAS_INT, 16'h1234);
      rd(RTD_ADDR_FLOAT_HI, 16'h4049);
      rd(RTD_ADDR_FLOAT_LO, 16'h0fdb);
      i_float_swap = 1'b1;
      rd(RTD_ADDR_FLOAT_HI, 16'h0fdb);
      rd(RTD_ADDR_FLOAT_LO, 16'h4049);
      i_float_swap = 1'b0;
      conv({16'h0a5a, 32'hc2c8_1111});
      conv({16'h00ff, 32'h437f_2222});
      rd(RTD_ADDR_MEAS_INT, 16'h00ff);
      rd(RTD_ADDR_FLOAT_HI, 16'h437f);
      rd(RTD_ADDR_FLOAT_LO, 16'h2222);
   endtask
   task automatic t_unmapped();
      access(1'b1, 16'h9c46, 16'h5555);
      rd(16'h9c46, 16'h0000);
      rd(RTD_ADDR_CFG, 16'h00f7);
   endtask
   // conversion then reads in the very next cycles
   task automatic t_back_to_back();
      @(posedge i_clk);
      #1;
      i_conv_valid = 1'b1;
      i_conv = {16'h7e57, 32'h4120_0000};
      @(posedge i_clk);
      #1;
      i_conv_valid = 1'b0;
      i_rd = 1'b1;
      i_addr = RTD_ADDR_MEAS_INT;
      @(posedge i_clk);
      #1;
      i_addr = RTD_ADDR_FLOAT_HI;
      check({15'h0000, o_rvalid}, 16'h0001);
      check(o_rdata, 16'h7e57);
      @(posedge i_clk);
      #1;
      i_rd = 1'b0;
      check({15'h0000, o_rvalid}, 16'h0001);
      check(o_rdata, 16'h4120);
      @(posedge i_clk);
      #1;
      check({15'h0000, o_rvalid}, 16'h0000);
   endtask
   initial begin
      repeat (2) @(posedge i_clk);
      #1;
      i_rst = 1'b0;
      t_reset();
      t_config();
      t_meas();
      t_back_to_back();
      t_unmapped();
      give_verdict();
   end
endmodule
`default_nettype wire
